// file: logic/dtcf_top.sv
/*
 * Debug trace and compare block: two address comparators, an eight-word
 * trace store read a byte at a time, and the debug control register.
 * Assumes the CPU bus, register port, mode inputs and secure flag are all
 * driven by logic on clk_i; the break request goes to the CPU core.
 */
`timescale 1ns/100ps
`include "dtcf_defs.svh"

// How it works
// R1: Comparator bytes reset to zero, always readable, locked while armed.
// R2: High and low bytes join into each sixteen-bit compare value.
// R3: Trace high byte is read-only, reads zero in event-only modes.
// R4: Reading trace high byte leaves the store where it is; read high first.
// R5: Reading trace low byte shifts the store; writes to it do nothing.
// R6: Event-only modes store bytes in the low half of each word.
// R7: While armed, low-byte reads do not shift; host waits for run end.
// R8: Unarmed low-byte reads push the last fetched opcode address.
// R9: Host primes profiling with eight reads; ninth returns the first.
// R10: Control register is read and written at any time.
// R11: Enable bit seven cannot be set while the part is secured.
// R12: Bit six arms; writing one sets it, run end or zero clears it.
// R13: Bit five picks tag or force break type; moot without break enable.
// R14: Bit four enables breaks: at trigger in end trace, at full in begin.
// R15: Bit two makes comparator A honour direction given by bit three.
// R16: Bit zero makes comparator B honour direction given by bit one.
// R17: Run ends when full in begin trace or on trigger in end trace.
// R18: Modes 0011 and 0100 store bytes on B events; others store words.
// R19: Arm flag follows arm while enabled, clears at run end unless an arm write comes in the same cycle.
// R20: Each comparator checks the bus address on valid cycles while enabled, with direction option.
module dtcf_top #(
    parameter int AW    = 16,
    parameter int DEPTH = 8,
    parameter int CW    = 4
) (
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic [3:0]    reg_addr_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [7:0]    reg_wdata_i,
    output logic      [7:0]    reg_rdata_o,
    input  wire logic          cpu_valid_i,
    input  wire logic [AW-1:0] cpu_addr_i,
    input  wire logic          cpu_rw_i,
    input  wire logic [7:0]    cpu_data_i,
    input  wire logic          opcode_fetch_i,
    input  wire logic          cof_i,
    input  wire logic          secure_i,
    input  wire logic [3:0]    trigger_mode_select_i,
    input  wire logic          begin_trace_i,
    output logic               brk_req_o,
    output logic               brk_tag_o,
    output logic               capture_active_flag_o,
    output logic      [CW-1:0] fifo_count_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    dtcf_pkg::dtcf_state_e state;
    dtcf_pkg::dtcf_state_e next_state;

    logic [7:0]    cmp_a_high_value;
    logic [7:0]    cmp_a_low_value;
    logic [7:0]    cmp_b_high_value;
    logic [7:0]    cmp_b_low_value;
    logic          module_enable_bit;
    logic [5:0]    ctrl_cfg;
    logic [AW-1:0] last_opcode_addr;
    logic [AW-1:0] fifo_head;
    logic [AW-1:0] fifo_din;
    logic          fifo_push;
    logic          a_seen;
    logic          a_match;
    logic          b_match;
    logic          a_ge;
    logic          b_le;
    logic          trigger;
    logic          armed;
    logic          wr_ctrl;
    logic          wr_cmp_ok;
    logic          rd_low;
    logic          arm_req;
    logic          arm_stop;
    logic          run_end;
    logic          run_start;
    logic          store;
    logic          ev_store;
    logic          full_now;
    logic          event_mode;
    logic          break_request_enable;
    logic          break_tag_select;

    assign break_request_enable = ctrl_cfg[`DTCF_BIT_BRK_EN];
    assign break_tag_select     = ctrl_cfg[`DTCF_BIT_TAG];

    // ****************************************************************
    // Access decode
    // ****************************************************************
    assign armed      = (state != dtcf_pkg::ST_IDLE);
    assign wr_ctrl    = reg_wr_i && (reg_addr_i == `DTCF_OFS_CONTROL);     // R10
    assign wr_cmp_ok  = reg_wr_i && !armed;                                // R1
    assign rd_low     = reg_rd_i && (reg_addr_i == `DTCF_OFS_FIFO_LOW);
    assign event_mode = (trigger_mode_select_i == `DTCF_TRG_EVENT_B) ||
                        (trigger_mode_select_i == `DTCF_TRG_A_EVENT_B);    // R18

    // Arming needs the enable in the same write, and the part unsecured
    assign arm_req  = wr_ctrl && reg_wdata_i[`DTCF_BIT_ARM] &&
                      reg_wdata_i[`DTCF_BIT_ENABLE] && !secure_i;          // R12 R11
    assign arm_stop = wr_ctrl && !arm_req;                                 // R12

    // ****************************************************************
    // Comparators
    // ****************************************************************
    dtcf_comparator #(
        .AW (AW)
    ) u_cmp_a (
        .value_i   ({cmp_a_high_value, cmp_a_low_value}),                  // R2
        .addr_i    (cpu_addr_i),
        .valid_i   (cpu_valid_i && module_enable_bit),
        .rw_i      (cpu_rw_i),
        .dir_en_i  (ctrl_cfg[`DTCF_BIT_A_DIR_EN]),
        .dir_val_i (ctrl_cfg[`DTCF_BIT_A_DIR_VAL]),
        .match_o   (a_match),
        .ge_o      (a_ge),
        .le_o      ()
    );

    dtcf_comparator #(
        .AW (AW)
    ) u_cmp_b (
        .value_i   ({cmp_b_high_value, cmp_b_low_value}),                  // R2
        .addr_i    (cpu_addr_i),
        .valid_i   (cpu_valid_i && module_enable_bit),
        .rw_i      (cpu_rw_i),
        .dir_en_i  (ctrl_cfg[`DTCF_BIT_B_DIR_EN]),
        .dir_val_i (ctrl_cfg[`DTCF_BIT_B_DIR_VAL]),
        .match_o   (b_match),
        .ge_o      (),
        .le_o      (b_le)
    );

    // ****************************************************************
    // Trigger selection
    // ****************************************************************
    always_comb begin
        case (trigger_mode_select_i)
            `DTCF_TRG_A_ONLY:    trigger = a_match;
            `DTCF_TRG_A_OR_B:    trigger = a_match || b_match;
            `DTCF_TRG_A_THEN_B:  trigger = a_seen && b_match;
            `DTCF_TRG_EVENT_B:   trigger = b_match;
            `DTCF_TRG_A_EVENT_B: trigger = a_seen && b_match;
            `DTCF_TRG_A_AND_B:   trigger = a_match && b_match;
            `DTCF_TRG_A_NOT_B:   trigger = a_match && !b_match;
            `DTCF_TRG_INSIDE:    trigger = a_ge && b_le;
            `DTCF_TRG_OUTSIDE:   trigger = cpu_valid_i && module_enable_bit && !(a_ge && b_le);
            default:             trigger = 1'b0;
        endcase
    end

    // A must be seen on an earlier cycle before B counts in sequence modes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || run_start) begin
            a_seen <= 1'b0;
        end else if (armed && a_match) begin
            a_seen <= 1'b1;
        end
    end

    // ****************************************************************
    // Storage decisions
    // ****************************************************************
    assign ev_store = b_match &&
                      ((trigger_mode_select_i == `DTCF_TRG_EVENT_B) || a_seen);  // R18
    always_comb begin
        store = 1'b0;
        if (state == dtcf_pkg::ST_FILL) begin
            store = event_mode ? ev_store : (cof_i && cpu_valid_i);
        end else if (state == dtcf_pkg::ST_CIRC) begin
            store = cof_i && cpu_valid_i;
        end
    end

    assign full_now = (state == dtcf_pkg::ST_FILL) && store &&
                      (fifo_count_o == CW'(DEPTH - 1));                      // R17
    assign run_end  = full_now || ((state == dtcf_pkg::ST_CIRC) && trigger); // R17
    assign run_start = arm_req && (!armed || run_end);

    // Armed reads never shift; unarmed low-byte reads push the last opcode address
    assign fifo_push = store || (rd_low && !armed);                          // R5 R7 R8
    assign fifo_din  = !store     ? last_opcode_addr :                       // R8
                       event_mode ? {{(AW-8){1'b0}}, cpu_data_i} :           // R6
                                    cpu_addr_i;

    dtcf_trace_fifo #(
        .WIDTH (AW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .push_i    (fifo_push),
        .data_i    (fifo_din),
        .head_o    (fifo_head)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            last_opcode_addr <= AW'(`DTCF_WORD_RST);
        end else if (opcode_fetch_i && cpu_valid_i) begin
            last_opcode_addr <= cpu_addr_i;
        end
    end

    // Count of valid words: cleared when a run starts, never decremented
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || run_start) begin
            fifo_count_o <= '0;
        end else if (store && armed && fifo_count_o != CW'(DEPTH)) begin
            fifo_count_o <= fifo_count_o + CW'(1);
        end
    end

    // ****************************************************************
    // Run state machine
    // ****************************************************************
    always_comb begin
        next_state = state;
        case (state)
            dtcf_pkg::ST_IDLE:    next_state = dtcf_pkg::ST_IDLE;
            dtcf_pkg::ST_PRETRIG: if (trigger) begin
                next_state = dtcf_pkg::ST_FILL;
            end
            dtcf_pkg::ST_FILL:    if (full_now) begin
                next_state = dtcf_pkg::ST_IDLE;                              // R17
            end
            dtcf_pkg::ST_CIRC:    if (trigger) begin
                next_state = dtcf_pkg::ST_IDLE;                              // R17
            end
            default:              next_state = dtcf_pkg::ST_IDLE;
        endcase
        // A fresh arm write beats a run end in the same cycle
        if (run_start) begin
            if (event_mode || begin_trace_i) begin
                next_state = event_mode ? dtcf_pkg::ST_FILL : dtcf_pkg::ST_PRETRIG;
            end else begin
                next_state = dtcf_pkg::ST_CIRC;
            end
        end else if (arm_stop) begin
            next_state = dtcf_pkg::ST_IDLE;                                  // R12
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state                 <= dtcf_pkg::ST_IDLE;
            capture_active_flag_o <= 1'b0;
        end else begin
            state                 <= next_state;
            capture_active_flag_o <= (next_state != dtcf_pkg::ST_IDLE);      // R19
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            module_enable_bit <= 1'b0;
            ctrl_cfg          <= `DTCF_CFG_RST;
        end else if (wr_ctrl) begin
            module_enable_bit <= reg_wdata_i[`DTCF_BIT_ENABLE] && !secure_i; // R11
            ctrl_cfg          <= reg_wdata_i[5:0];                           // R13 R14 R15 R16
        end
    end

    // ****************************************************************
    // Comparator value registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmp_a_high_value <= `DTCF_CMP_RST;
            cmp_a_low_value  <= `DTCF_CMP_RST;
            cmp_b_high_value <= `DTCF_CMP_RST;
            cmp_b_low_value  <= `DTCF_CMP_RST;
        end else if (wr_cmp_ok) begin                                        // R1
            case (reg_addr_i)
                `DTCF_OFS_CMP_A_HIGH: cmp_a_high_value <= reg_wdata_i;
                `DTCF_OFS_CMP_A_LOW:  cmp_a_low_value  <= reg_wdata_i;
                `DTCF_OFS_CMP_B_HIGH: cmp_b_high_value <= reg_wdata_i;
                `DTCF_OFS_CMP_B_LOW:  cmp_b_low_value  <= reg_wdata_i;
                default:              cmp_a_low_value  <= cmp_a_low_value;
            endcase
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // The head is sampled at the same edge that a low read shifts the store
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= `DTCF_BYTE_ZERO;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DTCF_OFS_CMP_A_HIGH: reg_rdata_o <= cmp_a_high_value;       // R1
                `DTCF_OFS_CMP_A_LOW:  reg_rdata_o <= cmp_a_low_value;
                `DTCF_OFS_CMP_B_HIGH: reg_rdata_o <= cmp_b_high_value;
                `DTCF_OFS_CMP_B_LOW:  reg_rdata_o <= cmp_b_low_value;
                `DTCF_OFS_FIFO_HIGH:  reg_rdata_o <= event_mode ? `DTCF_BYTE_ZERO
                                                                 : fifo_head[15:8]; // R3 R4
                `DTCF_OFS_FIFO_LOW:   reg_rdata_o <= fifo_head[7:0];        // R5
                `DTCF_OFS_CONTROL:    reg_rdata_o <= {module_enable_bit,
                                                      capture_active_flag_o,
                                                      ctrl_cfg};            // R10
                default:              reg_rdata_o <= `DTCF_BYTE_ZERO;
            endcase
        end
    end

    // ****************************************************************
    // Break request
    // ****************************************************************
    // One-cycle pulse; the type travels with it on brk_tag_o
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            brk_req_o <= 1'b0;
            brk_tag_o <= 1'b0;
        end else begin
            brk_req_o <= break_request_enable &&
                         (full_now || ((state == dtcf_pkg::ST_CIRC) && trigger)); // R14
            brk_tag_o <= break_request_enable && break_tag_select;                // R13
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_arm_write;
        wr_ctrl && reg_wdata_i[`DTCF_BIT_ARM] && reg_wdata_i[`DTCF_BIT_ENABLE] && !secure_i;
    endsequence

    sequence s_end_trigger;
        (state == dtcf_pkg::ST_CIRC) && trigger && break_request_enable;
    endsequence

    a_cmp_write_lock: assert property ( // R1
        armed && reg_wr_i |=> $stable(cmp_a_high_value) && $stable(cmp_b_low_value))
        else $error("comparator value changed while armed");

    a_fifo_high_zero: assert property ( // R3
        reg_rd_i && reg_addr_i == `DTCF_OFS_FIFO_HIGH && event_mode |=> reg_rdata_o == 8'h00)
        else $error("trace high byte not zero in event-only mode");

    a_high_no_shift: assert property ( // R4
        reg_rd_i && reg_addr_i == `DTCF_OFS_FIFO_HIGH && !store |=> $stable(fifo_head))
        else $error("trace high read moved the store");

    a_low_push_op: assert property ( // R8
        rd_low && !armed |-> fifo_push && fifo_din == last_opcode_addr)
        else $error("unarmed low read did not push opcode address");

    a_armed_no_shift: assert property ( // R7
        armed && !store |-> !fifo_push)
        else $error("store shifted by a read while armed");

    a_event_byte: assert property ( // R6
        store && event_mode |-> fifo_din[15:8] == 8'h00)
        else $error("event-only store wrote the high half");

    a_secure_enable: assert property ( // R11
        wr_ctrl && secure_i |=> !module_enable_bit)
        else $error("enable set while secured");

    a_arm_sets_flag: assert property ( // R12
        s_arm_write |=> capture_active_flag_o && state != dtcf_pkg::ST_IDLE)
        else $error("arm write did not arm");

    a_run_end_idle: assert property ( // R17
        run_end && !arm_req |=> !capture_active_flag_o ##1 !armed || run_start)
        else $error("run end left the block armed");

    a_brk_end_trace: assert property ( // R14
        s_end_trigger |=> brk_req_o ##1 !brk_req_o || run_end)
        else $error("end trace trigger gave no break pulse");

    a_flag_mirror: assert property ( // R19
        capture_active_flag_o |-> armed && module_enable_bit)
        else $error("arm flag set without an enabled armed run");

    a_dir_qual_a: assert property ( // R15
        a_match && ctrl_cfg[`DTCF_BIT_A_DIR_EN] |-> cpu_rw_i == ctrl_cfg[`DTCF_BIT_A_DIR_VAL])
        else $error("comparator A ignored direction");

    a_dir_qual_b: assert property ( // R16
        b_match && ctrl_cfg[`DTCF_BIT_B_DIR_EN] |-> cpu_rw_i == ctrl_cfg[`DTCF_BIT_B_DIR_VAL])
        else $error("comparator B ignored direction");

endmodule

// file: include/dtcf_defs.svh
/*
 * Register offsets, control bit positions, reset values and trigger mode codes
 * of the debug trace and compare block.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef DTCF_DEFS_SVH
`define DTCF_DEFS_SVH

// ****************************************************************
// Register offsets on the register port
// ****************************************************************
`define DTCF_OFS_CMP_A_HIGH  4'h0
`define DTCF_OFS_CMP_A_LOW   4'h1
`define DTCF_OFS_CMP_B_HIGH  4'h2
`define DTCF_OFS_CMP_B_LOW   4'h3
`define DTCF_OFS_FIFO_HIGH   4'h4
`define DTCF_OFS_FIFO_LOW    4'h5
`define DTCF_OFS_CONTROL     4'h6

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define DTCF_BIT_ENABLE      7
`define DTCF_BIT_ARM         6
`define DTCF_BIT_TAG         5
`define DTCF_BIT_BRK_EN      4
`define DTCF_BIT_A_DIR_VAL   3
`define DTCF_BIT_A_DIR_EN    2
`define DTCF_BIT_B_DIR_VAL   1
`define DTCF_BIT_B_DIR_EN    0

// ****************************************************************
// Reset values
// ****************************************************************
`define DTCF_CMP_RST         8'h00
`define DTCF_CFG_RST         6'h00
`define DTCF_BYTE_ZERO       8'h00
`define DTCF_WORD_RST        16'h0000

// ****************************************************************
// Trigger mode codes
// ****************************************************************
`define DTCF_TRG_A_ONLY      4'h0
`define DTCF_TRG_A_OR_B      4'h1
`define DTCF_TRG_A_THEN_B    4'h2
`define DTCF_TRG_EVENT_B     4'h3
`define DTCF_TRG_A_EVENT_B   4'h4
`define DTCF_TRG_A_AND_B     4'h5
`define DTCF_TRG_A_NOT_B     4'h6
`define DTCF_TRG_INSIDE      4'h7
`define DTCF_TRG_OUTSIDE     4'h8

`endif

// file: include/dtcf_pkg.sv
/*
 * Types shared by the debug trace and compare block.
 * Assumes nothing of its surroundings.
 */
package dtcf_pkg;

    // One-hot run states
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_PRETRIG = 4'b0010,
        ST_FILL    = 4'b0100,
        ST_CIRC    = 4'b1000
    } dtcf_state_e;

endpackage

// file: logic/dtcf_comparator.sv
/*
 * One address comparator with optional read/write qualification.
 * Assumes bus address and direction come from logic on the same clock.
 */
`timescale 1ns/100ps

module dtcf_comparator #(
    parameter int AW = 16
) (
    input  wire logic [AW-1:0] value_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          valid_i,
    input  wire logic          rw_i,
    input  wire logic          dir_en_i,
    input  wire logic          dir_val_i,
    output logic               match_o,
    output logic               ge_o,
    output logic               le_o
);

    logic dir_ok;

    // Direction only matters when its enable is set
    assign dir_ok  = !dir_en_i || (rw_i == dir_val_i);                 // R15 R16 R20
    assign match_o = valid_i && dir_ok && (addr_i == value_i);         // R20
    assign ge_o    = valid_i && dir_ok && (addr_i >= value_i);
    assign le_o    = valid_i && dir_ok && (addr_i <= value_i);

endmodule

// file: logic/dtcf_trace_fifo.sv
/*
 * Shift-style trace store: words enter at the tail, the head is read out.
 * Each push moves every word one place toward the head.
 * Assumes push and data come from logic on the same clock.
 */
`timescale 1ns/100ps
`include "dtcf_defs.svh"

module dtcf_trace_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic      [WIDTH-1:0] head_o
);

    logic [WIDTH-1:0] entry [DEPTH];

    // ****************************************************************
    // Storage chain
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    entry[g] <= WIDTH'(`DTCF_WORD_RST);
                end else if (push_i) begin
                    if (g == DEPTH - 1) begin
                        entry[g] <= data_i;
                    end else begin
                        // Wrapped index keeps the unused tail branch in range
                        entry[g] <= entry[(g + 1) % DEPTH];
                    end
                end
            end
        end
    endgenerate

    assign head_o = entry[0];

    a_push_tail_store: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
        push_i |=> entry[DEPTH-1] == $past(data_i))
        else $error("pushed word missing from the tail");

endmodule

// file: dv/dtcf_cpu_model.sv
/* CPU core bus model: an opcode fetch read every cycle at a set address,
   each one a change of flow so that full-mode runs store every cycle except in ST_PRETRIG.
   Assumes the bench clock; outputs move on the falling edge only. */
`timescale 1ns/100ps
module dtcf_cpu_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] fetch_addr_i,
    output logic             valid_o,
    output logic [15:0]      addr_o,
    output logic             rw_o,
    output logic [7:0]       data_o,
    output logic             fetch_o,
    output logic             cof_o
);
    initial {valid_o, addr_o, rw_o, data_o, fetch_o, cof_o} = '0;
    // Bus always busy, so no released value is ever shown
    always @(negedge clk_i) begin
        valid_o <= 1'b1;
        addr_o  <= fetch_addr_i;
        rw_o    <= 1'b1;
        data_o  <= ~fetch_addr_i[7:0];
        fetch_o <= 1'b1;
        cof_o   <= 1'b1;
    end
endmodule

// file: dv/tb_top.sv
/* Self-checking bench: register port, arming, lock, profiling reads.
   Assumes dtcf_cpu_model drives the CPU bus side. */
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("FAIL %0t got %h exp %h", $time, a, e); end end
module tb_top;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic        secure_i = 1'b0, begin_trace_i = 1'b0;
    logic        cpu_valid_i, cpu_rw_i, opcode_fetch_i, cof_i;
    logic        brk_req_o, brk_tag_o, capture_active_flag_o;
    logic [3:0]  reg_addr_i = 4'h0, trigger_mode_select_i = 4'hf, fifo_count_o;
    logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, cpu_data_i, d, q, hi, lo, v[4];
    logic [15:0] cpu_addr_i, fetch_addr = 16'h0000, f[12];
    logic [31:0] seed = 32'd51;
    int          num_errors = 0, comparisons = 0, brks = 0;
    dtcf_top uut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .cpu_valid_i, .cpu_addr_i, .cpu_rw_i, .cpu_data_i, .opcode_fetch_i,
        .cof_i, .secure_i, .trigger_mode_select_i, .begin_trace_i, .brk_req_o, .brk_tag_o,
        .capture_active_flag_o, .fifo_count_o);
    dtcf_cpu_model cpu (.clk_i, .fetch_addr_i(fetch_addr), .valid_o(cpu_valid_i),
        .addr_o(cpu_addr_i), .rw_o(cpu_rw_i), .data_o(cpu_data_i),
        .fetch_o(opcode_fetch_i), .cof_o(cof_i));
    always #2 clk_i = ~clk_i;
    // Break pulses stand one cycle; count them where they are settled
    always @(negedge clk_i) brks += brk_req_o;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] w);
        @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, w};
        @(negedge clk_i) reg_wr_i = 1'b0;
    endtask
    // Strobe drops on the next falling edge; data landed on the edge between
    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        @(negedge clk_i) {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge clk_i) reg_rd_i = 1'b0;
        r = reg_rdata_o;
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) sys_rst_i = 1'b0;
        // Low trace byte skipped here: reading it shifts the store
        for (int i = 0; i < 16; i++) begin
            if (i != 5) begin
                rd(i[3:0], d);
                `CHK(d, 8'h00)
            end
        end
        for (int i = 0; i < 4; i++) begin
            v[i] = rnd();
            wr(i[3:0], v[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd(i[3:0], d);
            `CHK(d, v[i])
        end
        d = rnd() & 8'h3f;
        wr(4'h6, d);
        rd(4'h6, q);
        `CHK(q, d)
        secure_i = 1'b1;
        wr(4'h6, 8'h80);
        rd(4'h6, q);
        `CHK(q[7], 1'b0)
        secure_i = 1'b0;
        wr(4'h6, 8'hc0);
        `CHK(capture_active_flag_o, 1'b1)
        wr(4'h0, ~v[0]);
        rd(4'h0, q);
        `CHK(q, v[0])
        wr(4'h6, 8'h80);
        `CHK(capture_active_flag_o, 1'b0)
        // Eight priming reads, then each pair returns the fetch of eight back
        for (int k = 0; k < 12; k++) begin
            f[k] = {rnd(), rnd()};
            fetch_addr = f[k];
            rd(4'h4, hi);
            rd(4'h5, lo);
            if (k >= 8) `CHK({hi, lo}, f[k-8])
        end
        trigger_mode_select_i = 4'h3;
        rd(4'h4, hi);
        `CHK(hi, 8'h00)
        // End trace on comparator A: every cycle stored, the match ends the run
        trigger_mode_select_i = 4'h0;
        fetch_addr = {v[0], ~v[1]};
        wr(4'h6, 8'hf0);
        repeat (10) @(negedge clk_i);
        fetch_addr = {v[0], v[1]};
        repeat (4) @(negedge clk_i);
        `CHK(capture_active_flag_o, 1'b0)
        `CHK(brks, 1)
        `CHK(brk_tag_o, 1'b1)
        `CHK(fifo_count_o, 4'h8)
        rd(4'h4, hi);
        rd(4'h5, lo);
        `CHK({hi, lo}, {v[0], ~v[1]})
        results();
    end
endmodule
